//--- common/hss_consts.svh
`ifndef HSS_CONSTS_SVH
`define HSS_CONSTS_SVH

// ----------------------------------------------------------------
// channel count and clock rate
// ----------------------------------------------------------------
`define HSS_NCH              4
`define HSS_CLK_PERIOD_NS    100

// ----------------------------------------------------------------
// timing figures and derived cycle counts
// ----------------------------------------------------------------
// board select filter, both edges
`define HSS_BSEL_FILT_NS     100000
`define HSS_BSEL_FILT_CYC    (`HSS_BSEL_FILT_NS / `HSS_CLK_PERIOD_NS)
// fault filter, least length 1 us rounded up (longest is 2 us)
`define HSS_FAULT_FILT_NS    1000
`define HSS_FAULT_FILT_CYC   ((`HSS_FAULT_FILT_NS + `HSS_CLK_PERIOD_NS - 1) / `HSS_CLK_PERIOD_NS)
// slow turn-on clamp after a channel is enabled
`define HSS_CLAMP_NS         500000
`define HSS_CLAMP_CYC        (`HSS_CLAMP_NS / `HSS_CLK_PERIOD_NS)
// plain two-flop synchroniser plus one settle cycle
`define HSS_SYNC_CYC         1

// ----------------------------------------------------------------
// ramp pulse numbering
// ----------------------------------------------------------------
`define HSS_LAST_RAMP_PULSE  3'h3
`define HSS_ENABLE_PULSE     3'h4

`endif

//--- common/hss_pkg.sv
package hss_pkg;

   // -------------------------------------------------------------
   // sequencer states
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF,
      ST_CHECK,
      ST_CHARGE,
      ST_DISCH,
      ST_GOOD,
      ST_LATCHED
   } hss_state_e;

   // -------------------------------------------------------------
   // analog comparator results, one bit per channel
   // -------------------------------------------------------------
   typedef struct packed {
      logic [3:0] win_ok;    // muxed voltage inside its uv/ov window
      logic [3:0] oc_fast;   // fast overcurrent comparator tripped
   } hss_cmp_s;

   // -------------------------------------------------------------
   // per-channel controls toward the gate blocks
   // -------------------------------------------------------------
   typedef struct packed {
      logic [3:0] amp_en;    // current control amp enable
      logic [3:0] ref_ramp;  // 1: reference follows ramp, 0: max limit
      logic [3:0] fast_dis;  // extra gate discharge paths
      logic [3:0] mon_en;    // voltage fault monitoring
   } hss_chan_s;

endpackage : hss_pkg

//--- hw/hss_filter.sv
`timescale 1ns/1ps
`include "hss_consts.svh"

module hss_filter #(
   parameter int unsigned FILT_CYC = 1,
   parameter logic        INIT     = 1'b0
) (
   // clock, reset, enable
   input  wire logic i_clk_sys,
   input  wire logic i_nrst,
   input  wire logic i_clk_en,
   // raw level and filtered level
   input  wire logic i_raw,
   output logic      o_filt
);

   logic        meta_reg;
   logic        sync_reg;
   logic        filt_reg;
   logic [15:0] cnt_reg;

   // -------------------------------------------------------------
   // two-flop synchroniser, first stage read only by the second
   // -------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_reg <= INIT;
         sync_reg <= INIT;
      end else if (i_clk_en) begin
         meta_reg <= i_raw;
         sync_reg <= meta_reg;
      end
   end

   // -------------------------------------------------------------
   // output follows only a level that stood FILT_CYC cycles
   // -------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         filt_reg <= INIT;
         cnt_reg  <= 16'h0000;
      end else if (i_clk_en) begin
         if (sync_reg == filt_reg) begin
            cnt_reg <= 16'h0000;           // glitch shorter than window dies here
         end else if (cnt_reg == 16'(FILT_CYC - 1)) begin
            filt_reg <= sync_reg;
            cnt_reg  <= 16'h0000;
         end else begin
            cnt_reg <= cnt_reg + 16'h0001;
         end
      end
   end

   assign o_filt = filt_reg;

endmodule : hss_filter

//--- hw/hss_sequencer.sv
// Contract
// R1: before first ramp, hold all switches off while any input supply is outside window.
// R2: when ramp-up starts, switch voltage comparators from supply input to load sense.
// R3: fast overcurrent trip disables that amp and turns on fast gate discharge.
// R4: ignore faults under 1-2 us; longer fault latches, drops power-good, stops all.
// R5: ramp-up uses five pulses; channels 1-4 on pulses 1-4, fifth enables channel-4 monitoring.
// R6: controller starts turn-on with board select low; start only if supplies in window.
// R7: each pulse charges ramp node to 1.5 V, then discharges to 0 V.
// R8: reference follows ramp while rising; max current limit during discharge.
// R9: pulse end advances channel, enables its amp, monitors channel just ramped.
// R10: channel below undervoltage when monitored is a fault; all off, sequence aborted.
// R11: stay latched after fault until board select goes high then low, or power cycles.
// R12: fifth pulse is short, using the fast 256 uA ramp currents.
// R13: drive power-good low only when all four channels good after fifth pulse.
// R14: after channel enable, clamp ramp output for about 500 us before fast charging.
// R15: board select passes a 100 us filter on both edges.
// R16: board select high while healthy releases power-good, turns channels off 4,3,2,1.
// R17: comparator, lockout and ramp inputs synchronised; channel controls are digital outputs.
// R18: lockout or reset holds all channels off and power-good released.
`timescale 1ns/1ps
`include "hss_consts.svh"

module hss_sequencer #(
   parameter int unsigned CLAMP_CYC = `HSS_CLAMP_CYC
) (
   // clock, reset, enable
   input  wire logic             i_clk_sys,
   input  wire logic             i_nrst,
   input  wire logic             i_clk_en,
   // backplane pins
   input  wire logic             i_board_select_n,
   output logic                  o_pgood_n_o,
   output logic                  o_pgood_n_oe,
   // analog sensing
   input  wire logic             i_supply_lockout,
   input  wire hss_pkg::hss_cmp_s i_cmp,
   input  wire logic             i_ramp_hi,
   input  wire logic             i_ramp_lo,
   // channel and ramp controls
   output hss_pkg::hss_chan_s    o_chan,
   output logic                  o_sense_load,
   output logic                  o_ramp_charge,
   output logic                  o_ramp_discharge,
   output logic                  o_ramp_fast,
   output logic                  o_ramp_clamp,
   output logic                  o_fault
);
   import hss_pkg::*;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   hss_state_e  state_reg;
   hss_chan_s   chan_reg;
   logic [2:0]  pulse_reg;
   logic        down_reg;
   logic        sense_load_reg;
   logic        charge_reg;
   logic        discharge_reg;
   logic        fast_reg;
   logic        fault_reg;
   logic        pgood_oe_reg;
   logic [15:0] clamp_cnt_reg;
   logic        clamp_reg;

   // synchronised inputs and conditions decoded from them
   logic        bsel_n_f;
   logic        lockout_s;
   logic        ramp_hi_s;
   logic        ramp_lo_s;
   logic [3:0]  vfault_f;
   logic [3:0]  oc_f;
   logic        fault_now;
   logic        active;
   logic        clamp_start;

   // -------------------------------------------------------------
   // input conditioning
   // -------------------------------------------------------------
   // board select rests high so a floating pin never starts a turn-on
   hss_filter #(.FILT_CYC(`HSS_BSEL_FILT_CYC), .INIT(1'b1)) u_bsel (    // R15
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_clk_en  (i_clk_en),
      .i_raw     (i_board_select_n),
      .o_filt    (bsel_n_f)
   );

   // lockout assumed active until seen otherwise
   hss_filter #(.FILT_CYC(`HSS_SYNC_CYC), .INIT(1'b1)) u_lock (         // R17
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_clk_en  (i_clk_en),
      .i_raw     (i_supply_lockout),
      .o_filt    (lockout_s)
   );

   hss_filter #(.FILT_CYC(`HSS_SYNC_CYC), .INIT(1'b0)) u_hi (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_clk_en  (i_clk_en),
      .i_raw     (i_ramp_hi),
      .o_filt    (ramp_hi_s)
   );

   hss_filter #(.FILT_CYC(`HSS_SYNC_CYC), .INIT(1'b0)) u_lo (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_clk_en  (i_clk_en),
      .i_raw     (i_ramp_lo),
      .o_filt    (ramp_lo_s)
   );

   // per-channel fault filters for voltage window and fast overcurrent
   for (genvar ch = 0; ch < `HSS_NCH; ch++) begin : g_ch
      hss_filter #(.FILT_CYC(`HSS_FAULT_FILT_CYC), .INIT(1'b0)) u_vf (   // R4
         .i_clk_sys (i_clk_sys),
         .i_nrst    (i_nrst),
         .i_clk_en  (i_clk_en),
         .i_raw     (~i_cmp.win_ok[ch]),
         .o_filt    (vfault_f[ch])
      );
      hss_filter #(.FILT_CYC(`HSS_FAULT_FILT_CYC), .INIT(1'b0)) u_oc (   // R4
         .i_clk_sys (i_clk_sys),
         .i_nrst    (i_nrst),
         .i_clk_en  (i_clk_en),
         .i_raw     (i_cmp.oc_fast[ch]),
         .o_filt    (oc_f[ch])
      );
   end

   // -------------------------------------------------------------
   // fault detection while rails may be live
   // -------------------------------------------------------------
   assign active    = (state_reg == ST_CHARGE) || (state_reg == ST_DISCH) || (state_reg == ST_GOOD);
   assign fault_now = active &&
                      (|((oc_f & chan_reg.amp_en) | (vfault_f & chan_reg.mon_en)));   // R4 R10

   // -------------------------------------------------------------
   // main sequencer: ramp pulses, channel enables, latch-off
   // -------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg      <= ST_OFF;                                    // R18
         chan_reg       <= '0;
         pulse_reg      <= 3'h0;
         down_reg       <= 1'b0;
         sense_load_reg <= 1'b0;
         charge_reg     <= 1'b0;
         discharge_reg  <= 1'b0;
         fast_reg       <= 1'b0;
         fault_reg      <= 1'b0;
      end else if (i_clk_en) begin
         if (lockout_s) begin
            // lockout overrides everything, also clears a latched fault
            state_reg      <= ST_OFF;                                 // R18
            chan_reg       <= '0;
            pulse_reg      <= 3'h0;
            down_reg       <= 1'b0;
            sense_load_reg <= 1'b0;
            charge_reg     <= 1'b0;
            discharge_reg  <= 1'b0;
            fast_reg       <= 1'b0;
            fault_reg      <= 1'b0;
         end else if (fault_now) begin
            // one channel failing shuts all four; live ones get fast discharge
            state_reg       <= ST_LATCHED;                            // R4 R10
            chan_reg.amp_en   <= 4'h0;                                // R3
            chan_reg.fast_dis <= chan_reg.amp_en | oc_f;              // R3
            chan_reg.ref_ramp <= 4'h0;
            chan_reg.mon_en   <= 4'h0;
            charge_reg      <= 1'b0;
            discharge_reg   <= 1'b0;
            fast_reg        <= 1'b0;
            fault_reg       <= 1'b1;
         end else begin
            case (state_reg)
               ST_OFF: begin
                  chan_reg       <= '0;
                  sense_load_reg <= 1'b0;
                  fault_reg      <= 1'b0;
                  if (!bsel_n_f) begin
                     state_reg <= ST_CHECK;                           // R6
                  end
               end
               ST_CHECK: begin
                  // switches stay off until every input supply is in window
                  if (bsel_n_f) begin
                     state_reg <= ST_OFF;
                  end else if (vfault_f == 4'h0) begin                // R1 R6
                     state_reg         <= ST_CHARGE;
                     sense_load_reg    <= 1'b1;                       // R2
                     chan_reg.amp_en   <= 4'h1;                       // R5
                     chan_reg.ref_ramp <= 4'h1;                       // R8
                     pulse_reg         <= 3'h0;
                     down_reg          <= 1'b0;
                     charge_reg        <= 1'b1;                       // R7
                  end
               end
               ST_CHARGE: begin
                  if (ramp_hi_s) begin
                     state_reg         <= ST_DISCH;
                     charge_reg        <= 1'b0;                       // R7
                     discharge_reg     <= 1'b1;
                     chan_reg.ref_ramp <= 4'h0;                       // R8
                  end
               end
               ST_DISCH: begin
                  if (ramp_lo_s) begin
                     discharge_reg <= 1'b0;                           // R7
                     if (!down_reg) begin
                        if (pulse_reg < `HSS_LAST_RAMP_PULSE) begin
                           // next channel on, previous one now watched
                           chan_reg.amp_en[pulse_reg[1:0] + 2'h1] <= 1'b1;           // R9
                           chan_reg.ref_ramp <= 4'h1 << (pulse_reg[1:0] + 2'h1);   // R8
                           chan_reg.mon_en[pulse_reg[1:0]] <= 1'b1;                // R9
                           pulse_reg  <= pulse_reg + 3'h1;
                           charge_reg <= 1'b1;
                           state_reg  <= ST_CHARGE;
                        end else if (pulse_reg == `HSS_LAST_RAMP_PULSE) begin
                           chan_reg.mon_en[3] <= 1'b1;                // R5 R9
                           fast_reg   <= 1'b1;                        // R12
                           pulse_reg  <= `HSS_ENABLE_PULSE;
                           charge_reg <= 1'b1;
                           state_reg  <= ST_CHARGE;
                        end else begin
                           fast_reg  <= 1'b0;
                           state_reg <= ST_GOOD;                      // R13
                        end
                     end else begin
                        // ramp-down: pulse k (1 to 4) ends by turning off channel 5-k
                        fast_reg <= 1'b0;
                        if (pulse_reg != 3'h0) begin
                           chan_reg.amp_en[2'(3'h4 - pulse_reg)] <= 1'b0;          // R16
                           chan_reg.fast_dis[2'(3'h4 - pulse_reg)] <= 1'b1;
                        end
                        if (pulse_reg == `HSS_ENABLE_PULSE) begin
                           state_reg      <= ST_OFF;
                           down_reg       <= 1'b0;
                           sense_load_reg <= 1'b0;
                        end else begin
                           if (pulse_reg < 3'h3) begin
                              chan_reg.mon_en[2'(3'h2 - pulse_reg)] <= 1'b0;       // R16
                           end
                           pulse_reg  <= pulse_reg + 3'h1;
                           charge_reg <= 1'b1;
                           state_reg  <= ST_CHARGE;
                        end
                     end
                  end
               end
               ST_GOOD: begin
                  if (bsel_n_f) begin
                     // short first pulse drops channel 4 monitoring, then channel 3 monitoring at its end
                     state_reg          <= ST_CHARGE;                 // R16
                     down_reg           <= 1'b1;
                     pulse_reg          <= 3'h0;
                     chan_reg.mon_en[3] <= 1'b0;
                     fast_reg           <= 1'b1;
                     charge_reg         <= 1'b1;
                  end
               end
               ST_LATCHED: begin
                  // a board select release or a lockout clears the latch
                  chan_reg.amp_en <= 4'h0;
                  if (bsel_n_f) begin
                     state_reg <= ST_OFF;                             // R11
                  end
               end
               default: begin
                  state_reg <= ST_OFF;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // slow turn-on clamp on each ramp-up channel enable
   // -------------------------------------------------------------
   assign clamp_start = !lockout_s && !fault_now &&
                        (((state_reg == ST_CHECK) && !bsel_n_f && (vfault_f == 4'h0)) ||
                         ((state_reg == ST_DISCH) && ramp_lo_s && !down_reg &&
                          (pulse_reg < `HSS_LAST_RAMP_PULSE)));

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         clamp_cnt_reg <= 16'h0000;
         clamp_reg     <= 1'b0;
      end else if (i_clk_en) begin
         if (clamp_start) begin
            clamp_cnt_reg <= 16'(CLAMP_CYC - 1);                      // R14
            clamp_reg     <= 1'b1;
         end else if (lockout_s || fault_now || (clamp_cnt_reg == 16'h0000)) begin
            clamp_cnt_reg <= 16'h0000;
            clamp_reg     <= 1'b0;                                    // R14
         end else begin
            clamp_cnt_reg <= clamp_cnt_reg - 16'h0001;
         end
      end
   end

   // -------------------------------------------------------------
   // power-good: pulled low only while healthy and still selected
   // -------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         pgood_oe_reg <= 1'b0;                                        // R18
      end else if (i_clk_en) begin
         pgood_oe_reg <= (state_reg == ST_GOOD) && !bsel_n_f && !fault_now && !lockout_s;   // R13 R16
      end
   end

   // -------------------------------------------------------------
   // outputs straight from flops, pgood data tied low
   // -------------------------------------------------------------
   assign o_chan           = chan_reg;                               // R17
   assign o_sense_load     = sense_load_reg;
   assign o_ramp_charge    = charge_reg;
   assign o_ramp_discharge = discharge_reg;
   assign o_ramp_fast      = fast_reg;
   assign o_ramp_clamp     = clamp_reg;
   assign o_fault          = fault_reg;
   assign o_pgood_n_oe     = pgood_oe_reg;
   assign o_pgood_n_o      = 1'b0;                                    // open drain only pulls low

endmodule : hss_sequencer

//--- test/hss_seq_checker.sv
`timescale 1ns/1ps
module hss_seq_checker #(
   parameter int unsigned CLAMP_CYC = 20
) (
   // clock and reset
   input wire logic              i_clk_sys,
   input wire logic              i_nrst,
   // watched inputs
   input wire logic              i_board_select_n,
   input wire logic              i_supply_lockout,
   input wire hss_pkg::hss_cmp_s i_cmp,
   // watched outputs
   input wire hss_pkg::hss_chan_s o_chan,
   input wire logic              o_pgood_n_oe,
   input wire logic              o_sense_load,
   input wire logic              o_ramp_charge,
   input wire logic              o_ramp_discharge,
   input wire logic              o_ramp_fast,
   input wire logic              o_ramp_clamp,
   input wire logic              o_fault
);
   import hss_pkg::*;
   int unsigned clamp_cnt_reg;

   // clamp run length
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst)
         clamp_cnt_reg <= 0;
      else
         clamp_cnt_reg <= o_ramp_clamp ? clamp_cnt_reg + 1 : 0;
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // select held low, lockout off
   sequence s_quiet; (!i_board_select_n && !i_supply_lockout) [*4]; endsequence
   sequence s_oc_hit; (|(i_cmp.oc_fast & o_chan.amp_en)) [*8] ##1 (|i_cmp.oc_fast) [*6]; endsequence
   property p_pg_full; o_pgood_n_oe |-> o_chan.amp_en == 4'hF && o_chan.mon_en == 4'hF; endproperty
   property p_fault_off; $rose(o_fault) |-> o_chan.amp_en == 4'h0 && !o_pgood_n_oe; endproperty
   property p_latch; s_quiet ##0 o_fault |=> o_fault; endproperty
   property p_lock; i_supply_lockout [*5] |-> o_chan == 16'h0000 && !o_pgood_n_oe; endproperty
   property p_oc; s_oc_hit |-> o_fault && (|o_chan.fast_dis); endproperty
   property p_excl; !(o_ramp_charge && o_ramp_discharge); endproperty
   property p_sense; (|o_chan.amp_en) |-> o_sense_load; endproperty
   property p_start; $rose(|o_chan.amp_en) |-> $past(&i_cmp.win_ok, 3); endproperty
   property p_fast; o_ramp_fast |-> o_chan.amp_en == 4'hF; endproperty
   property p_clamp; $fell(o_ramp_clamp) && !o_fault |-> clamp_cnt_reg + 1 >= CLAMP_CYC
      && clamp_cnt_reg <= CLAMP_CYC + 1; endproperty

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_pg_full: assert property (p_pg_full) else $error("power good without all rails live");
   a_fault_off: assert property (p_fault_off) else $error("fault left a rail or power good on");
   a_latch: assert property (p_latch) else $error("fault cleared with select low");
   a_lock: assert property (p_lock) else $error("rail on during lockout");
   a_oc: assert property (p_oc) else $error("overcurrent did not trip");
   a_excl: assert property (p_excl) else $error("ramp charge and discharge together");
   a_sense: assert property (p_sense) else $error("comparators not on load sense");
   a_start: assert property (p_start) else $error("ramp began with a supply out of window");
   a_fast: assert property (p_fast) else $error("fast ramp outside the short pulses");
   a_clamp: assert property (p_clamp) else $error("clamp length wrong");
endmodule : hss_seq_checker

bind hss_sequencer hss_seq_checker #(.CLAMP_CYC(CLAMP_CYC)) u_chk (
   .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_board_select_n(i_board_select_n),
   .i_supply_lockout(i_supply_lockout), .i_cmp(i_cmp), .o_chan(o_chan), .o_pgood_n_oe(o_pgood_n_oe),
   .o_sense_load(o_sense_load), .o_ramp_charge(o_ramp_charge), .o_ramp_discharge(o_ramp_discharge),
   .o_ramp_fast(o_ramp_fast), .o_ramp_clamp(o_ramp_clamp), .o_fault(o_fault));

//--- test/hss_ramp_model.sv
`timescale 1ns/1ps
module hss_ramp_model (
   // clock
   input  wire logic       i_clk_sys,
   // ramp controls from the sequencer
   input  wire logic       i_charge,
   input  wire logic       i_discharge,
   input  wire logic       i_fast,
   input  wire logic       i_clamp,
   input  wire logic [7:0] i_top,
   // threshold crossings back
   output logic            o_ramp_hi,
   output logic            o_ramp_lo
);
   logic [7:0] lvl_reg = 8'h00;
   logic [7:0] top;

   // short pulse uses a small top, standing in for the large currents
   assign top = i_fast ? 8'h04 : i_top;
   // node climbs while charged, held near ground by the clamp, falls to zero
   always @(posedge i_clk_sys) begin
      if (i_charge && !i_clamp && lvl_reg < top)
         lvl_reg <= lvl_reg + 8'h01;
      else if (i_discharge && lvl_reg != 8'h00)
         lvl_reg <= lvl_reg - 8'h01;
   end
   assign o_ramp_hi = lvl_reg >= top;
   assign o_ramp_lo = lvl_reg == 8'h00;
endmodule : hss_ramp_model

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
   import hss_pkg::*;
   localparam int CLAMP = 20;
   logic       clk_sys = 1'b0;
   logic       nrst = 1'b0;
   logic       bsel_n = 1'b1;
   logic       lockout = 1'b0, clk_en = 1'b1;
   hss_cmp_s   cmp = 8'hF0;
   logic [7:0] top = 8'h20;
   logic       ramp_hi, ramp_lo, pg_oe, chg, dis, fast, clamp, fault, pg_o, sense;
   hss_chan_s  chan;
   int         n_errors = 0, n_compared = 0, cyc = 0, seed = 16284, nchg = 0, ch = 0;
   logic [5:0] exp_q[$];
   logic [1:0] ev_prev = 2'b00;
   logic [3:0] dn[4] = '{4'h7, 4'h3, 4'h1, 4'h0};

   // ------------------------------------------------------------
   // design, far side and clock
   // ------------------------------------------------------------
   hss_sequencer #(.CLAMP_CYC(CLAMP)) uut (
      .i_clk_sys(clk_sys), .i_nrst(nrst), .i_clk_en(clk_en), .i_board_select_n(bsel_n),
      .o_pgood_n_o(pg_o), .o_pgood_n_oe(pg_oe), .i_supply_lockout(lockout), .i_cmp(cmp),
      .i_ramp_hi(ramp_hi), .i_ramp_lo(ramp_lo), .o_chan(chan), .o_sense_load(sense),
      .o_ramp_charge(chg), .o_ramp_discharge(dis), .o_ramp_fast(fast), .o_ramp_clamp(clamp),
      .o_fault(fault));
   hss_ramp_model u_ramp (
      .i_clk_sys(clk_sys), .i_charge(chg), .i_discharge(dis), .i_fast(fast), .i_clamp(clamp),
      .i_top(top), .o_ramp_hi(ramp_hi), .o_ramp_lo(ramp_lo));
   always #50 clk_sys = ~clk_sys;

   // ------------------------------------------------------------
   // checking and ending
   // ------------------------------------------------------------
   task check(input logic [5:0] seen, input logic [5:0] expv);
      n_compared++;
      if (seen !== expv) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask : check

   task results;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   // every change of power good or fault takes the oldest note
   always @(posedge clk_sys) begin
      if (nrst && {pg_oe, fault} !== ev_prev)
         check({pg_oe, fault, chan.amp_en}, exp_q.size() ? exp_q.pop_front() : 6'hXX);
      ev_prev <= {pg_oe, fault};
   end

   // watchdog, well past the run
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         results();
      end
   end

   // ramp pulses seen, to count a turn-on
   always @(posedge chg) nchg++;

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   // new select level with a fresh random pulse height
   task sel(input logic v);
      @(posedge clk_sys);
      bsel_n <= v;
      top <= 8'h18 + 8'($random(seed) & 15);
   endtask : sel

   task pulse_oc(input int n);
      @(posedge clk_sys);
      cmp.oc_fast[ch] <= 1'b1;
      repeat (n) @(posedge clk_sys);
      cmp.oc_fast[ch] <= 1'b0;
   endtask : pulse_oc

   initial begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check({pg_oe, fault, chan.amp_en}, 6'h00);
      // a supply out of window keeps every rail off
      sel(1'b0);
      cmp.win_ok <= 4'hE;
      repeat (1300) @(posedge clk_sys);
      check({2'b00, chan.amp_en}, 6'h00);
      nchg = 0;
      exp_q.push_back(6'h2F);
      cmp.win_ok <= 4'hF;
      @(posedge clk_sys iff pg_oe);
      check({pg_o, sense, 4'(nchg)}, 6'h15);
      // orderly shutdown, rails off last to first
      exp_q.push_back(6'h0F);
      sel(1'b1);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys iff chan.amp_en !== (i ? dn[i - 1] : 4'hF));
         check({2'b00, chan.amp_en}, {2'b00, dn[i]});
      end
      // short overcurrent ignored, long one latches everything off
      ch = $random(seed) & 3;
      exp_q.push_back(6'h2F);
      sel(1'b0);
      @(posedge clk_sys iff pg_oe);
      pulse_oc(5);
      repeat (40) @(posedge clk_sys);
      check({pg_oe, fault, chan.amp_en}, 6'h2F);
      exp_q.push_back(6'h10);
      pulse_oc(20);
      check({5'h00, chan.fast_dis[ch]}, 6'h01);
      repeat (1200) @(posedge clk_sys);
      check({5'h00, fault}, 6'h01);
      exp_q.push_back(6'h00);
      sel(1'b1);
      repeat (1100) @(posedge clk_sys);
      // channel 1 short of its threshold when monitoring begins
      exp_q.push_back(6'h10);
      sel(1'b0);
      @(posedge clk_sys iff chg);
      cmp.win_ok <= 4'hE;
      @(posedge clk_sys iff fault);
      // lockout clears the latch; the bad supply then holds the restart
      exp_q.push_back(6'h00);
      @(posedge clk_sys);
      lockout <= 1'b1;
      repeat (50) @(posedge clk_sys);
      lockout <= 1'b0;
      repeat (200) @(posedge clk_sys);
      check({2'b00, chan.amp_en}, 6'h00);
      exp_q.push_back(6'h2F);
      cmp.win_ok <= 4'hF;
      @(posedge clk_sys iff pg_oe);
      clk_en <= 1'b0;
      sel(1'b1);
      repeat (1100) @(posedge clk_sys);
      check({pg_oe, 5'(exp_q.size())}, 6'h20);
      results();
   end
endmodule : tb
